//--- inc/wp_pkg.sv
// constants and types of the two-comparator watchpoint unit
package wp_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_CAP = 12'h000;
  localparam logic [11:0] OFF_REF0 = 12'h020;
  localparam logic [11:0] OFF_IGN0 = 12'h024;
  localparam logic [11:0] OFF_FCT0 = 12'h028;
  localparam logic [11:0] CMP_STRIDE = 12'h010;
  localparam logic [11:0] OFF_REF1 = OFF_REF0 + CMP_STRIDE;
  localparam logic [11:0] OFF_IGN1 = OFF_IGN0 + CMP_STRIDE;
  localparam logic [11:0] OFF_FCT1 = OFF_FCT0 + CMP_STRIDE;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h040;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h044;
  // capability word
  localparam logic [3:0] COMPARATOR_COUNT = 4'h2;
  localparam logic [27:0] FEATURE_DISABLE_WORD = 28'hF00_0000;
  localparam logic [31:0] CAP_WORD =
    {COMPARATOR_COUNT, FEATURE_DISABLE_WORD};
  // reset values
  localparam logic [31:0] REF_RESET = 32'h0000_0000;
  localparam logic [4:0] IGN_RESET = 5'h00;
  localparam logic [4:0] IGN_MAX = 5'h18;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  // function register field positions
  localparam int FCT_FN_LSB = 0;
  localparam int FCT_DVM_BIT = 8;
  localparam int FCT_DVS_LSB = 10;
  localparam int FCT_LINK_BIT = 12;
  localparam int FCT_MATCH_BIT = 24;
  // ignore count field
  localparam int IGN_LSB = 0;
  // watch type of a comparator
  typedef enum logic [3:0] {
    WP_FN_OFF = 4'b0000,
    WP_FN_FETCH = 4'b0100,
    WP_FN_READ = 4'b0101,
    WP_FN_WRITE = 4'b0110,
    WP_FN_RDWR = 4'b0111
  } wp_fn_t;
  // data value size
  typedef enum logic [1:0] {
    WP_SZ_BYTE = 2'b00,
    WP_SZ_HALF = 2'b01,
    WP_SZ_WORD = 2'b10,
    WP_SZ_RSVD = 2'b11
  } wp_size_t;
endpackage

//--- logic/wp_sticky.sv
// sticky flags, set wins over clear
`timescale 1ns/1ps
module wp_sticky #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  output logic [WIDTH-1:0] flag_o
);
  // per bit: set has priority over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= '0;
    end else begin
      flag_o <= set_i | (flag_o & ~clr_i);
    end
  end
endmodule

//--- logic/wp_comparator.sv
// one address / data value comparator
`timescale 1ns/1ps
module wp_comparator #(
  parameter bit DATA_CAPABLE = 1'b0
) (
  input wire logic [31:0] ref_i,
  input wire logic [4:0] ign_i,
  input wire wp_pkg::wp_fn_t fn_i,
  input wire wp_pkg::wp_size_t dv_size_i,
  input wire logic acc_valid_i,
  input wire logic [31:0] acc_addr_i,
  input wire logic [31:0] acc_data_i,
  input wire logic [1:0] acc_size_i,
  input wire logic acc_fetch_i,
  input wire logic acc_write_i,
  output logic addr_hit_o,
  output logic data_hit_o
);
  logic type_ok;
  logic [31:0] care;
  logic data_eq;

  // access kind against watch type
  always_comb begin
    type_ok = 1'b0;
    unique case (fn_i)
      wp_pkg::WP_FN_FETCH: type_ok = acc_fetch_i;
      wp_pkg::WP_FN_READ: type_ok = !acc_fetch_i && !acc_write_i;
      wp_pkg::WP_FN_WRITE: type_ok = !acc_fetch_i && acc_write_i;
      wp_pkg::WP_FN_RDWR: type_ok = !acc_fetch_i;
      default: type_ok = 1'b0; // off or unused code
    endcase
  end

  // bits kept in the address compare
  always_comb begin
    care = 32'hFFFF_FFFF << ign_i;
    if (ign_i == 5'h00 && fn_i == wp_pkg::WP_FN_FETCH) begin
      care[0] = 1'b0;
    end
  end

  // evaluated in the cycle the access is presented
  assign addr_hit_o = acc_valid_i && type_ok
    && (((acc_addr_i ^ ref_i) & care) == 32'h0000_0000);

  // data lane compare, reference replicated by software
  always_comb begin
    data_eq = 1'b0;
    unique case (dv_size_i)
      wp_pkg::WP_SZ_BYTE:
        data_eq = acc_data_i[8*acc_addr_i[1:0] +: 8]
          == ref_i[8*acc_addr_i[1:0] +: 8];
      wp_pkg::WP_SZ_HALF:
        data_eq = acc_data_i[16*acc_addr_i[1] +: 16]
          == ref_i[16*acc_addr_i[1] +: 16];
      wp_pkg::WP_SZ_WORD: data_eq = acc_data_i == ref_i;
      default: data_eq = 1'b0; // reserved size never matches
    endcase
  end

  // data hit needs same access size; only on comparator 0
  assign data_hit_o = DATA_CAPABLE && acc_valid_i && type_ok
    && !acc_fetch_i && (acc_size_i == dv_size_i) && data_eq;
endmodule

//--- logic/wp_unit.sv
// top of the two-comparator watchpoint unit
//
// Overview of operation
// - capability word is read-only; writes change nothing.
// - top four capability bits report two comparators.
// - low 28 capability bits are a fixed feature-disable constant.
// - capability bits 27..24 read one: trace, match pins, counters absent.
// - remaining capability bits read zero; no packets or events.
// - two 32-bit reference registers, reset zero, 16-byte stride.
// - mask register holds five-bit ignore count; upper bits read zero.
// - ignore count zero compares every address bit on read, write and read-or-write watch.
// - ignore count zero on fetch watch still drops address bit 0.
// - ignore count x drops address bits x-1 down to 0.
// - masked comparator matches when bits 31 down to x agree.
// - ignore count is clamped to 24 on write.
// - comparator 0 does address or data value; comparator 1 address.
// - sticky match flag per comparator, cleared by reading function reg.
// - data size 00 byte, 01 halfword, 10 word, 11 reserved.
`timescale 1ns/1ps
module wp_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // observed processor access
  input wire logic acc_valid_i,
  input wire logic [31:0] acc_addr_i,
  input wire logic [31:0] acc_data_i,
  input wire logic [1:0] acc_size_i,
  input wire logic acc_fetch_i,
  input wire logic acc_write_i,
  // match events
  output logic [1:0] match_o,
  output logic irq_o
);
  // software state
  logic [31:0] ref0;
  logic [31:0] ref1;
  logic [4:0] ign0;
  logic [4:0] ign1;
  wp_pkg::wp_fn_t fn0;
  wp_pkg::wp_fn_t fn1;
  logic data_value_match_enable;
  wp_pkg::wp_size_t data_value_size;
  logic link_comp1;
  logic [1:0] irq_mask;

  // capability word fields, all hardwired
  logic [3:0] comparator_count;
  logic trace_packets_absent;
  logic external_match_absent;
  logic cycle_counter_absent;
  logic profile_counters_absent;
  logic cap_spare_23;
  logic underflow_packet_enable;
  logic [4:0] counter_event_enables;
  logic exception_trace_enable;
  logic [2:0] cap_spare_15_13;
  logic pc_sampling_enable;
  logic [1:0] sync_packet_tap;
  logic cycle_tap_select;
  logic [3:0] post_reload_value;
  logic [3:0] post_preset_value;
  logic cycle_count_enable;
  logic [31:0] cap_word;

  // decoded strobes
  logic wr_ref0;
  logic wr_ref1;
  logic wr_ign0;
  logic wr_ign1;
  logic wr_fct0;
  logic wr_fct1;
  logic wr_stat;
  logic wr_mask;
  logic rd_fct0;
  logic rd_fct1;

  // comparator results
  logic addr_hit0;
  logic addr_hit1;
  logic data_hit0;
  logic unused_data_hit1;
  logic [1:0] next_match;
  logic [1:0] matched;
  logic [1:0] irq_stat;
  logic [4:0] next_ign;
  logic [31:0] next_rdata;
  logic [1:0] flag_clr;
  logic [1:0] stat_clr;

  // write and read decode
  assign wr_ref0 = wr_i && addr_i == wp_pkg::OFF_REF0;
  assign wr_ref1 = wr_i && addr_i == wp_pkg::OFF_REF1;
  assign wr_ign0 = wr_i && addr_i == wp_pkg::OFF_IGN0;
  assign wr_ign1 = wr_i && addr_i == wp_pkg::OFF_IGN1;
  assign wr_fct0 = wr_i && addr_i == wp_pkg::OFF_FCT0;
  assign wr_fct1 = wr_i && addr_i == wp_pkg::OFF_FCT1;
  assign wr_stat = wr_i && addr_i == wp_pkg::OFF_IRQ_STAT;
  assign wr_mask = wr_i && addr_i == wp_pkg::OFF_IRQ_MASK;
  assign rd_fct0 = rd_i && addr_i == wp_pkg::OFF_FCT0;
  assign rd_fct1 = rd_i && addr_i == wp_pkg::OFF_FCT1;

  // capability fields: count from COMPARATOR_COUNT, the rest from the fixed disable word
  assign comparator_count = wp_pkg::COMPARATOR_COUNT;
  assign trace_packets_absent = wp_pkg::FEATURE_DISABLE_WORD[27];
  assign external_match_absent = wp_pkg::FEATURE_DISABLE_WORD[26];
  assign cycle_counter_absent = wp_pkg::FEATURE_DISABLE_WORD[25];
  assign profile_counters_absent = wp_pkg::FEATURE_DISABLE_WORD[24];
  assign cap_spare_23 = wp_pkg::FEATURE_DISABLE_WORD[23];
  assign underflow_packet_enable = wp_pkg::FEATURE_DISABLE_WORD[22];
  assign counter_event_enables = wp_pkg::FEATURE_DISABLE_WORD[21:17];
  assign exception_trace_enable = wp_pkg::FEATURE_DISABLE_WORD[16];
  assign cap_spare_15_13 = wp_pkg::FEATURE_DISABLE_WORD[15:13];
  assign pc_sampling_enable = wp_pkg::FEATURE_DISABLE_WORD[12];
  assign sync_packet_tap = wp_pkg::FEATURE_DISABLE_WORD[11:10];
  assign cycle_tap_select = wp_pkg::FEATURE_DISABLE_WORD[9];
  assign post_reload_value = wp_pkg::FEATURE_DISABLE_WORD[8:5];
  assign post_preset_value = wp_pkg::FEATURE_DISABLE_WORD[4:1];
  assign cycle_count_enable = wp_pkg::FEATURE_DISABLE_WORD[0];

  // capability word, nothing writable behind it
  assign cap_word = {comparator_count, trace_packets_absent,
    external_match_absent, cycle_counter_absent, profile_counters_absent,
    cap_spare_23, underflow_packet_enable, counter_event_enables,
    exception_trace_enable, cap_spare_15_13, pc_sampling_enable,
    sync_packet_tap, cycle_tap_select, post_reload_value,
    post_preset_value, cycle_count_enable};

  // clamped ignore count from write data
  always_comb begin
    next_ign = wdata_i[wp_pkg::IGN_LSB +: 5];
    if (next_ign > wp_pkg::IGN_MAX) begin
      next_ign = wp_pkg::IGN_MAX;
    end
  end

  // reference value registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref0 <= wp_pkg::REF_RESET;
      ref1 <= wp_pkg::REF_RESET;
    end else begin
      if (wr_ref0) begin
        ref0 <= wdata_i;
      end
      if (wr_ref1) begin
        ref1 <= wdata_i;
      end
    end
  end

  // ignore count registers, upper bits not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ign0 <= wp_pkg::IGN_RESET;
      ign1 <= wp_pkg::IGN_RESET;
    end else begin
      if (wr_ign0) begin
        ign0 <= next_ign;
      end
      if (wr_ign1) begin
        ign1 <= next_ign;
      end
    end
  end

  // comparator 0 watch type
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fn0 <= wp_pkg::WP_FN_OFF;
    end else if (wr_fct0) begin
      fn0 <= wp_pkg::wp_fn_t'(wdata_i[wp_pkg::FCT_FN_LSB +: 4]);
    end
  end

  // comparator 0 data value controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_value_match_enable <= 1'b0;
      data_value_size <= wp_pkg::WP_SZ_BYTE;
    end else if (wr_fct0) begin
      data_value_match_enable <= wdata_i[wp_pkg::FCT_DVM_BIT];
      data_value_size <=
        wp_pkg::wp_size_t'(wdata_i[wp_pkg::FCT_DVS_LSB +: 2]);
    end
  end

  // comparator 0 data match linked to comparator 1 address hit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_comp1 <= 1'b0;
    end else if (wr_fct0) begin
      link_comp1 <= wdata_i[wp_pkg::FCT_LINK_BIT];
    end
  end

  // comparator 1 function register, address only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fn1 <= wp_pkg::WP_FN_OFF;
    end else if (wr_fct1) begin
      fn1 <= wp_pkg::wp_fn_t'(wdata_i[wp_pkg::FCT_FN_LSB +: 4]);
    end
  end

  // interrupt mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= wp_pkg::IRQ_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask <= wdata_i[1:0];
    end
  end

  // comparator 0: address or data value
  wp_comparator #(
    .DATA_CAPABLE(1'b1)
  ) u_cmp0 (
    .ref_i(ref0),
    .ign_i(ign0),
    .fn_i(fn0),
    .dv_size_i(data_value_size),
    .acc_valid_i(acc_valid_i),
    .acc_addr_i(acc_addr_i),
    .acc_data_i(acc_data_i),
    .acc_size_i(acc_size_i),
    .acc_fetch_i(acc_fetch_i),
    .acc_write_i(acc_write_i),
    .addr_hit_o(addr_hit0),
    .data_hit_o(data_hit0)
  );

  // comparator 1: address only
  wp_comparator #(
    .DATA_CAPABLE(1'b0)
  ) u_cmp1 (
    .ref_i(ref1),
    .ign_i(ign1),
    .fn_i(fn1),
    .dv_size_i(wp_pkg::WP_SZ_BYTE),
    .acc_valid_i(acc_valid_i),
    .acc_addr_i(acc_addr_i),
    .acc_data_i(acc_data_i),
    .acc_size_i(acc_size_i),
    .acc_fetch_i(acc_fetch_i),
    .acc_write_i(acc_write_i),
    .addr_hit_o(addr_hit1),
    .data_hit_o(unused_data_hit1)
  );

  // match selection; data mode ignores the ignore count
  always_comb begin
    next_match[1] = addr_hit1;
    if (data_value_match_enable) begin
      next_match[0] = data_hit0 && (!link_comp1 || addr_hit1);
    end else begin
      next_match[0] = addr_hit0;
    end
  end

  // match pulses one edge after the access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_o <= 2'h0;
    end else begin
      match_o <= next_match;
    end
  end

  // clear requests: function reads and write-one-to-clear
  assign flag_clr = {rd_fct1, rd_fct0};
  assign stat_clr = wr_stat ? wdata_i[1:0] : 2'h0;

  // sticky match flags, cleared by reading function register
  wp_sticky #(
    .WIDTH(2)
  ) u_matched (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(next_match),
    .clr_i(flag_clr),
    .flag_o(matched)
  );

  // interrupt status, write one to clear
  wp_sticky #(
    .WIDTH(2)
  ) u_irq_stat (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(next_match),
    .clr_i(stat_clr),
    .flag_o(irq_stat)
  );

  // level interrupt from unmasked status
  assign irq_o = |(irq_stat & irq_mask);

  // read data selection; unmapped reads give zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (addr_i)
      wp_pkg::OFF_CAP: next_rdata = cap_word;
      wp_pkg::OFF_REF0: next_rdata = ref0;
      wp_pkg::OFF_REF1: next_rdata = ref1;
      wp_pkg::OFF_IGN0: next_rdata[4:0] = ign0;
      wp_pkg::OFF_IGN1: next_rdata[4:0] = ign1;
      wp_pkg::OFF_FCT0: begin
        next_rdata[wp_pkg::FCT_FN_LSB +: 4] = fn0;
        next_rdata[wp_pkg::FCT_DVM_BIT] = data_value_match_enable;
        next_rdata[wp_pkg::FCT_DVS_LSB +: 2] = data_value_size;
        next_rdata[wp_pkg::FCT_LINK_BIT] = link_comp1;
        next_rdata[wp_pkg::FCT_MATCH_BIT] = matched[0];
      end
      wp_pkg::OFF_FCT1: begin
        next_rdata[wp_pkg::FCT_FN_LSB +: 4] = fn1;
        next_rdata[wp_pkg::FCT_MATCH_BIT] = matched[1];
      end
      wp_pkg::OFF_IRQ_STAT: next_rdata[1:0] = irq_stat;
      wp_pkg::OFF_IRQ_MASK: next_rdata[1:0] = irq_mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule

//--- dv/wp_unit_properties.sv
// port assertions for the watchpoint unit
`timescale 1ns/1ps
module wp_unit_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic acc_valid_i,
  input wire logic [31:0] acc_addr_i,
  input wire logic [31:0] acc_data_i,
  input wire logic [1:0] acc_size_i,
  input wire logic acc_fetch_i,
  input wire logic acc_write_i,
  input wire logic [1:0] match_o,
  input wire logic irq_o
);
  logic rd_q;
  logic [11:0] ad_q;
  logic ign_rd;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // remember the read request of the last cycle
  always_ff @(posedge clk_i) begin
    rd_q <= rd_i & ~rst_i;
    ad_q <= addr_i;
  end
  // answer slot of an ignore count read
  assign ign_rd = rd_q && (ad_q == 12'h024 || ad_q == 12'h034);
  a_cap_count: assert property (
    rd_q && ad_q == 12'h000 |-> rdata_o[31:28] == 4'h2)
    else $error("capability count wrong");
  a_cap_absent: assert property (
    $past(rd_i) && $past(addr_i) == 12'h000 |-> rdata_o[27:24] == 4'hF)
    else $error("capability absent bits wrong");
  a_cap_zeros: assert property (
    rd_q && ad_q == 12'h000 |-> rdata_o[23:0] == 24'h0)
    else $error("capability low bits wrong");
  a_ign_upper: assert property (
    ign_rd |-> rdata_o[31:5] == 27'h0)
    else $error("ignore count upper bits set");
  a_ign_clamp: assert property (
    ign_rd |-> rdata_o[4:0] <= 5'h18)
    else $error("ignore count above limit");
  a_match_cause: assert property (
    match_o != 2'h0 |-> $past(acc_valid_i))
    else $error("match without access");
  a_rdata_idle: assert property (
    rd_i ##1 !rd_i |=> rdata_o == 32'h0)
    else $error("read data outside answer slot");
  a_unmapped_zero: assert property (
    rd_q && ad_q == 12'h100 |-> rdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule

//--- dv/wp_cpu_model.sv
// processor access source watched by the unit
`timescale 1ns/1ps
module wp_cpu_model (
  input wire logic clk_i,
  output logic acc_valid_o,
  output logic [31:0] acc_addr_o,
  output logic [31:0] acc_data_o,
  output logic [1:0] acc_size_o,
  output logic acc_fetch_o,
  output logic acc_write_o
);
  // idle bus at start
  initial begin
    acc_valid_o = 1'h0;
    acc_addr_o = 32'hFFFF_FFFF;
    acc_data_o = 32'hFFFF_FFFF;
    acc_size_o = 2'h3;
    acc_fetch_o = 1'h0;
    acc_write_o = 1'h0;
  end
  // one access for one cycle; released bus shows inverted address and data
  task automatic access(input logic [31:0] a, input logic [31:0] d,
                        input logic [1:0] s, input logic f, input logic w);
    @(posedge clk_i);
    acc_valid_o <= 1'h1;
    acc_addr_o <= a;
    acc_data_o <= d;
    acc_size_o <= s;
    acc_fetch_o <= f;
    acc_write_o <= w;
    @(posedge clk_i);
    acc_valid_o <= 1'h0;
    acc_addr_o <= ~a;
    acc_data_o <= ~d;
  endtask
endmodule

//--- dv/wp_unit_tb.sv
// self-checking bench for the watchpoint unit
`timescale 1ns/1ps
bind wp_unit wp_unit_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .acc_valid_i(acc_valid_i),
  .acc_addr_i(acc_addr_i), .acc_data_i(acc_data_i),
  .acc_size_i(acc_size_i), .acc_fetch_i(acc_fetch_i),
  .acc_write_i(acc_write_i), .match_o(match_o), .irq_o(irq_o));
module wp_unit_tb;
  typedef struct packed {
    logic [31:0] a;
    logic [1:0] s;
    logic f;
    logic w;
    logic [1:0] m;
  } wp_row_t;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic [31:0] rdata_o;
  logic [31:0] acc_addr_i;
  logic [31:0] acc_data_i;
  logic [1:0] acc_size_i;
  logic [1:0] match_o;
  logic acc_valid_i;
  logic acc_fetch_i;
  logic acc_write_i;
  logic irq_o;
  int failures = 0;
  int n_checks = 0;
  // address, size, fetch, write, expected match
  wp_row_t rows [7] = '{
    '{32'h0000_2000, 2'h1, 1'h1, 1'h0, 2'h1},
    '{32'h0000_2002, 2'h1, 1'h1, 1'h0, 2'h0},
    '{32'h0000_2001, 2'h0, 1'h0, 1'h0, 2'h0},
    '{32'h0000_300F, 2'h0, 1'h0, 1'h0, 2'h2},
    '{32'h0000_3010, 2'h0, 1'h0, 1'h0, 2'h0},
    '{32'h0000_2FFF, 2'h0, 1'h0, 1'h0, 2'h0},
    '{32'h0000_3004, 2'h2, 1'h0, 1'h1, 2'h0}};
  wp_unit dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .acc_valid_i(acc_valid_i), .acc_addr_i(acc_addr_i),
    .acc_data_i(acc_data_i), .acc_size_i(acc_size_i),
    .acc_fetch_i(acc_fetch_i), .acc_write_i(acc_write_i),
    .match_o(match_o), .irq_o(irq_o));
  wp_cpu_model cpu (.clk_i(clk_i), .acc_valid_o(acc_valid_i),
    .acc_addr_o(acc_addr_i), .acc_data_o(acc_data_i),
    .acc_size_o(acc_size_i), .acc_fetch_o(acc_fetch_i),
    .acc_write_o(acc_write_i));
  // 20 MHz clock
  always #25 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
    #1;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1;
    chk($sformatf("reg %h", a), e, rdata_o);
  endtask
  task automatic acc_chk(input logic [31:0] a, input logic [31:0] d,
                         input logic [1:0] s, input logic f,
                         input logic w, input logic [1:0] e);
    cpu.access(a, d, s, f, w);
    #1;
    chk("match", 32'(e), 32'(match_o));
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    rdc(12'h000, 32'h2F00_0000);
    rdc(12'h020, 32'h0);
    rdc(12'h034, 32'h0);
    rdc(12'h100, 32'h0);
    wr(12'h000, 32'h0);
    rdc(12'h000, 32'h2F00_0000);
    wr(12'h024, 32'h0000_001F);
    rdc(12'h024, 32'h0000_0018);
    wr(12'h034, 32'hFFFF_FFE4);
    rdc(12'h034, 32'h0000_0004);
    wr(12'h024, 32'h0);
    wr(12'h020, 32'h0000_2001);
    wr(12'h028, 32'h0000_0004);
    wr(12'h030, 32'h0000_3000);
    rdc(12'h030, 32'h0000_3000);
    wr(12'h038, 32'h0000_0105);
    rdc(12'h038, 32'h0000_0005);
    foreach (rows[i]) begin
      cpu.access(rows[i].a, 32'h0, rows[i].s, rows[i].f, rows[i].w);
      #1;
      chk("match", 32'(rows[i].m), 32'(match_o));
    end
    rdc(12'h038, 32'h0100_0005);
    rdc(12'h038, 32'h0000_0005);
    chk("irq", 32'h0, {31'h0, irq_o});
    wr(12'h044, 32'h0000_0001);
    chk("irq", 32'h1, {31'h0, irq_o});
    wr(12'h040, 32'h0000_0001);
    chk("irq", 32'h0, {31'h0, irq_o});
    wr(12'h020, 32'h5A5A_5A5A);
    wr(12'h024, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(12'h028, {20'h0, s[1:0], 10'h105});
      cpu.access(32'h0000_4000, 32'h5A5A_5A5A, s[1:0], 1'h0, 1'h0);
      #1;
      chk("data match", {31'h0, s != 3}, {30'h0, match_o});
    end
    wr(12'h028, 32'h0000_0105);
    cpu.access(32'h0000_4001, 32'h0000_5B00, 2'h0, 1'h0, 1'h0);
    #1;
    chk("data miss", 32'h0, {30'h0, match_o});
    rdc(12'h028, 32'h0100_0105);
    chk("irq", 32'h1, {31'h0, irq_o});
    wr(12'h040, 32'h0000_0003);
    chk("irq", 32'h0, {31'h0, irq_o});
    // data match linked to comparator 1 address hit
    wr(12'h028, 32'h0000_1105);
    acc_chk(32'h0000_3001, 32'h0000_5A00, 2'h0, 1'h0, 1'h0, 2'h3);
    acc_chk(32'h0000_4001, 32'h0000_5A00, 2'h0, 1'h0, 1'h0, 2'h0);
    // write, read-or-write and off watch types on comparator 1
    wr(12'h038, 32'h0000_0006);
    acc_chk(32'h0000_3004, 32'h0, 2'h2, 1'h0, 1'h1, 2'h2);
    acc_chk(32'h0000_3004, 32'h0, 2'h2, 1'h0, 1'h0, 2'h0);
    wr(12'h038, 32'h0000_0007);
    acc_chk(32'h0000_3004, 32'h0, 2'h2, 1'h0, 1'h1, 2'h2);
    acc_chk(32'h0000_3004, 32'h0, 2'h1, 1'h1, 1'h0, 2'h0);
    wr(12'h038, 32'h0000_0000);
    acc_chk(32'h0000_3004, 32'h0, 2'h2, 1'h0, 1'h0, 2'h0);
    wr(12'h044, 32'h0000_0002);
    chk("irq", 32'h1, {31'h0, irq_o});
    // reset in mid-run returns comparator 1 and interrupt mask registers to their reset values
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    #1;
    chk("irq", 32'h0, {31'h0, irq_o});
    chk("match", 32'h0, 32'(match_o));
    rdc(12'h030, 32'h0);
    rdc(12'h034, 32'h0);
    rdc(12'h038, 32'h0);
    rdc(12'h044, 32'h0);
    rdc(12'h000, 32'h2F00_0000);
    tally_and_finish;
  end
endmodule
